// [logic/mrr_exec_regs.vh]
`ifndef MRR_EXEC_REGS_VH
`define MRR_EXEC_REGS_VH
// Avalon register word offsets (byte addresses)
`define MRR_REG_INSTR 8'h00
`define MRR_REG_WORK 8'h04
`define MRR_REG_STATUS 8'h08
`define MRR_REG_PC 8'h0C
`define MRR_REG_STACK 8'h10
`define MRR_REG_FILE_IDX 8'h14
`define MRR_REG_FILE_DATA 8'h18
// Status register fields
`define MRR_ST_CARRY 0
`define MRR_ST_ZERO 2
`define MRR_ST_IRQEN 7
// Reset values
`define MRR_RST_WORK 8'h00
`define MRR_RST_STATUS 8'h00
`define MRR_RST_PC 13'h0000
// Opcodes, 14-bit encoding
`define MRR_OP_NOP 14'h0000
`define MRR_OP_INTRET 14'h0009
`define MRR_MASK_FD 6'h3F
`define MRR_OPC_STORE 7'h01
`define MRR_OPC_COPY 6'h08
`define MRR_OPC_ROTL 6'h0D
`define MRR_OPC_LOADLIT 4'hC
`define MRR_OPC_RETLIT 4'hD
// Cycles per instruction, return stack depth
`define MRR_CYC_ONE 2'h1
`define MRR_CYC_TWO 2'h2
`define MRR_STACK_DEPTH 8
`endif

// [logic/mrr_file_ram.v]
`timescale 1ns/100ps
module mrr_file_ram (
   // Clock
   input wire clk,
   // Execution write port
   input wire exWe,
   input wire [6:0] exAddr,
   input wire [7:0] exWdata,
   // Read ports
   input wire [6:0] rdAddrA,
   output wire [7:0] rdDataA,
   input wire [6:0] rdAddrB,
   output wire [7:0] rdDataB,
   // Software write port, lower priority
   input wire swWe,
   input wire [6:0] swAddr,
   input wire [7:0] swWdata
);
   // No reset: file register contents are undefined at power-up
   reg [7:0] mem [0:127];
   assign rdDataA = mem[rdAddrA];
   assign rdDataB = mem[rdAddrB];
   always @(posedge clk) begin
      if (exWe) begin
         mem[exAddr] <= exWdata;
      end else if (swWe) begin
         mem[swAddr] <= swWdata;
      end
   end
endmodule

// [logic/mrr_exec.v]
// Summary of operation
// - Copy file to W or back by d
// - Copy file updates zero flag only
// - Load literal into W, no flags
// - Interrupt return pops PC, sets enable
// - Store W into file, no flags
// - Literal return loads W, pops PC
// - Literal return takes two cycles
// - Rotate left through carry, carry only
`timescale 1ns/100ps
`include "mrr_exec_regs.vh"
module mrr_exec (
   // Clock and reset
   input wire clk,
   input wire resetn,
   // Avalon-MM slave
   input wire [7:0] avsAddress,
   input wire avsRead,
   input wire avsWrite,
   input wire [31:0] avsWritedata,
   output reg [31:0] avsReaddata,
   output wire avsWaitrequest,
   // Execution status
   output wire execBusy
);
   // Two-cycle instructions spend their second cycle in ST_WAIT
   localparam ST_IDLE = 2'd0;
   localparam ST_EXEC = 2'd1;
   localparam ST_WAIT = 2'd2;

   reg [1:0] state_r;
   reg [1:0] cycLeft_r;
   reg [13:0] instr_r;
   reg [7:0] work_r;
   reg [7:0] status_r;
   reg [12:0] pc_r;
   // Eight-deep return stack, pointer wraps both ways
   reg [12:0] stack_r [0:`MRR_STACK_DEPTH-1];
   reg [2:0] sp_r;
   reg [6:0] fileIdx_r;
   // Read handshake
   reg rdDone_r;
   reg [7:0] work_nxt;
   reg [7:0] status_nxt;
   reg [12:0] pc_nxt;
   reg fileWe;
   reg [7:0] fileWdata;
   reg pop;
   reg [1:0] cycles;
   wire [7:0] fileVal;
   wire [7:0] swFileVal;
   wire [6:0] fIdx;
   wire destFile;
   wire [7:0] lit;
   wire [2:0] spTop;
   wire [12:0] stackTop;
   wire swWr;
   wire swRd;
   wire execNow;
   integer i;

   assign fIdx = instr_r[6:0];
   assign destFile = instr_r[7];
   assign lit = instr_r[7:0];
   assign spTop = sp_r - 3'd1;
   assign stackTop = stack_r[spTop];
   assign execBusy = (state_r != ST_IDLE);
   // The held instruction lingers after its execute cycle, so file writes are gated
   assign execNow = (state_r == ST_EXEC);
   // Writes stall while an instruction runs so software never races the core
   // Reads cost one wait state because read data come from a register
   assign swRd = avsRead & ~rdDone_r;
   assign avsWaitrequest = (avsWrite & execBusy) | swRd;
   assign swWr = avsWrite & ~execBusy;

   // Port A follows the operand, port B the software index
   mrr_file_ram uRam (
      .clk(clk),
      .exWe(fileWe & execNow),
      .exAddr(fIdx),
      .exWdata(fileWdata),
      .rdAddrA(fIdx),
      .rdDataA(fileVal),
      .rdAddrB(fileIdx_r),
      .rdDataB(swFileVal),
      .swWe(swWr && avsAddress == `MRR_REG_FILE_DATA),
      .swAddr(fileIdx_r),
      .swWdata(avsWritedata[7:0])
   );

   // Decode and execute the instruction held in instr_r
   always @* begin
      work_nxt = work_r;
      status_nxt = status_r;
      pc_nxt = pc_r + 13'd1;
      fileWe = 1'b0;
      fileWdata = fileVal;
      pop = 1'b0;
      cycles = `MRR_CYC_ONE;
      if (instr_r == `MRR_OP_NOP) begin
         work_nxt = work_r;
      end else if (instr_r == `MRR_OP_INTRET) begin
         pc_nxt = stackTop;
         pop = 1'b1;
         status_nxt[`MRR_ST_IRQEN] = 1'b1;
         cycles = `MRR_CYC_TWO;
      end else if (instr_r[13:7] == `MRR_OPC_STORE) begin
         fileWe = 1'b1;
         fileWdata = work_r;
      end else if (instr_r[13:8] == `MRR_OPC_COPY) begin
         status_nxt[`MRR_ST_ZERO] = (fileVal == 8'h00);
         if (destFile) begin
            fileWe = 1'b1;
         end else begin
            work_nxt = fileVal;
         end
      end else if (instr_r[13:8] == `MRR_OPC_ROTL) begin
         fileWdata = {fileVal[6:0], status_r[`MRR_ST_CARRY]};
         status_nxt[`MRR_ST_CARRY] = fileVal[7];
         if (destFile) begin
            fileWe = 1'b1;
         end else begin
            work_nxt = {fileVal[6:0], status_r[`MRR_ST_CARRY]};
         end
      // Bits 9:8 of both literal forms are don't-care
      end else if (instr_r[13:10] == `MRR_OPC_RETLIT) begin
         work_nxt = lit;
         pc_nxt = stackTop;
         pop = 1'b1;
         cycles = `MRR_CYC_TWO;
      end else if (instr_r[13:10] == `MRR_OPC_LOADLIT) begin
         work_nxt = lit;
      end
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_r <= ST_IDLE;
         cycLeft_r <= 2'd0;
         instr_r <= 14'h0000;
         work_r <= `MRR_RST_WORK;
         status_r <= `MRR_RST_STATUS;
         pc_r <= `MRR_RST_PC;
         sp_r <= 3'd0;
         fileIdx_r <= 7'h00;
         // A pop on an untouched stack then returns zero
         for (i = 0; i < `MRR_STACK_DEPTH; i = i + 1) begin
            stack_r[i] <= 13'h0000;
         end
      end else begin
         case (state_r)
            ST_IDLE: begin
               // Software writes land only here, so no register has two writers
               if (swWr) begin
                  case (avsAddress)
                     `MRR_REG_INSTR: begin
                        instr_r <= avsWritedata[13:0];
                        state_r <= ST_EXEC;
                     end
                     `MRR_REG_WORK: work_r <= avsWritedata[7:0];
                     `MRR_REG_STATUS: status_r <= avsWritedata[7:0];
                     `MRR_REG_PC: pc_r <= avsWritedata[12:0];
                     `MRR_REG_STACK: begin
                        // Push a return address
                        stack_r[sp_r] <= avsWritedata[12:0];
                        sp_r <= sp_r + 3'd1;
                     end
                     `MRR_REG_FILE_IDX: fileIdx_r <= avsWritedata[6:0];
                     default: ;
                  endcase
               end
            end
            ST_EXEC: begin
               work_r <= work_nxt;
               status_r <= status_nxt;
               pc_r <= pc_nxt;
               // Popping an empty stack wraps the pointer; there is no underflow flag
               if (pop) begin
                  sp_r <= spTop;
               end
               if (cycles == `MRR_CYC_TWO) begin
                  cycLeft_r <= cycles - 2'd1;
                  state_r <= ST_WAIT;
               end else begin
                  state_r <= ST_IDLE;
               end
            end
            ST_WAIT: begin
               // Second cycle of a return changes no state
               cycLeft_r <= cycLeft_r - 2'd1;
               if (cycLeft_r == 2'd1) begin
                  state_r <= ST_IDLE;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // Read data are captured in the first read cycle and stand in the second;
   // unmapped addresses read zero
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdDone_r <= 1'b0;
         avsReaddata <= 32'h0000_0000;
      end else begin
         rdDone_r <= swRd;
         if (swRd) begin
            case (avsAddress)
               `MRR_REG_INSTR: avsReaddata <= {18'h0_0000, instr_r};
               `MRR_REG_WORK: avsReaddata <= {24'h00_0000, work_r};
               `MRR_REG_STATUS: avsReaddata <= {24'h00_0000, status_r};
               `MRR_REG_PC: avsReaddata <= {19'h0_0000, pc_r};
               `MRR_REG_STACK: avsReaddata <= {16'h0000, 1'b0, sp_r, 12'h000};
               `MRR_REG_FILE_IDX: avsReaddata <= {25'h000_0000, fileIdx_r};
               `MRR_REG_FILE_DATA: avsReaddata <= {24'h00_0000, swFileVal};
               default: avsReaddata <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule

// [dv/mrr_exec_asserts.sv]
`timescale 1ns/100ps
module mrr_exec_asserts (
   // Clock and reset
   input wire clk,
   input wire resetn,
   // Bus
   input wire [7:0] avsAddress,
   input wire avsRead,
   input wire avsWrite,
   input wire [31:0] avsWritedata,
   input wire [31:0] avsReaddata,
   input wire avsWaitrequest,
   input wire execBusy
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   wire go = avsWrite && !avsWaitrequest && avsAddress == 8'h00;
   wire [13:0] op = avsWritedata[13:0];
   sequence oneCyc;
      ##1 execBusy ##1 !execBusy;
   endsequence
   sequence twoCyc;
      ##1 execBusy [*2] ##1 !execBusy;
   endsequence
   AST_NOP_ONE: assert property (go && op == 14'h0000 |-> oneCyc)
      else $error("nop busy length wrong");
   AST_LOAD_ONE: assert property (go && op[13:10] == 4'hC |-> oneCyc)
      else $error("load busy length wrong");
   AST_STORE_ONE: assert property (go && op[13:7] == 7'h01 |-> oneCyc)
      else $error("store busy length wrong");
   AST_COPY_ONE: assert property (go && op[13:8] == 6'h08 |-> oneCyc)
      else $error("copy busy length wrong");
   AST_ROT_ONE: assert property (go && op[13:8] == 6'h0D |-> oneCyc)
      else $error("rotate busy length wrong");
   AST_RETLIT_TWO: assert property (go && op[13:10] == 4'hD |-> twoCyc)
      else $error("literal return not two cycles");
   AST_RETINT_TWO: assert property (go && op == 14'h0009 |-> twoCyc)
      else $error("interrupt return not two cycles");
   // Writes must stall so an instruction is never overwritten mid-flight
   AST_STALL: assert property (avsWrite && execBusy |-> avsWaitrequest)
      else $error("write not stalled while busy");
   // A held read is answered after one wait state
   AST_RD_WAIT: assert property (avsRead && avsWaitrequest |=> !avsRead || !avsWaitrequest)
      else $error("read not answered after one wait state");
endmodule
bind mrr_exec mrr_exec_asserts mrr_exec_asserts_inst (.clk(clk), .resetn(resetn),
   .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
   .avsWritedata(avsWritedata), .avsReaddata(avsReaddata),
   .avsWaitrequest(avsWaitrequest), .execBusy(execBusy));

// [dv/test_mrr_exec.sv]
`timescale 1ns/100ps
module test_mrr_exec;
   reg clk = 0;
   reg resetn = 0;
   reg [7:0] adr = 0;
   reg rd = 0;
   reg wr = 0;
   reg [31:0] wd = 0;
   reg [31:0] got;
   wire [31:0] rdat;
   wire wt;
   wire busy;
   integer error_cnt = 0;
   integer cmp_count = 0;
   integer cyc = 0;
   integer busyCyc = 0;
   mrr_exec mrr_exec_inst (.clk(clk), .resetn(resetn), .avsAddress(adr), .avsRead(rd),
      .avsWrite(wr), .avsWritedata(wd), .avsReaddata(rdat), .avsWaitrequest(wt),
      .execBusy(busy));
   initial begin
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         error_cnt = error_cnt + 1;
         complete_run;
      end
   end
   task bus(input w, input [7:0] a, input [31:0] d);
      begin
         @(posedge clk);
         adr <= a;
         wr <= w;
         rd <= !w;
         wd <= d;
         @(posedge clk);
         while (wt) @(posedge clk);
         got = rdat;
         wr <= 0;
         rd <= 0;
      end
   endtask
   task rc(input [7:0] a, input [31:0] e);
      begin
         bus(0, a, 0);
         cmp_count = cmp_count + 1;
         if (got !== e) begin
            error_cnt = error_cnt + 1;
            $display("[ERR] reg %h expected %h seen %h", a, e, got);
         end
      end
   endtask
   task ex(input [13:0] i);
      begin
         bus(1, 0, i);
         busyCyc = 0;
         @(posedge clk);
         while (busy) begin
            busyCyc = busyCyc + 1;
            @(posedge clk);
         end
      end
   endtask
   task cyc_chk(input integer e);
      begin
         cmp_count = cmp_count + 1;
         if (busyCyc !== e) begin
            error_cnt = error_cnt + 1;
            $display("[ERR] busy cycles expected %0d seen %0d", e, busyCyc);
         end
      end
   endtask
   task t_load;
      begin
         bus(1, 8'h08, 5);
         ex(14'h30FF);
         rc(8'h04, 8'hFF);
         rc(8'h08, 5);
         bus(1, 8'h14, 8'h7F);
         ex(14'h00FF);
         rc(8'h18, 8'hFF);
         rc(8'h08, 5);
         $display("load store done");
      end
   endtask
   task t_copy;
      begin
         bus(1, 8'h14, 3);
         bus(1, 8'h18, 0);
         bus(1, 8'h08, 1);
         ex(14'h0803);
         rc(8'h04, 0);
         rc(8'h08, 5);
         bus(1, 8'h18, 8'h80);
         ex(14'h0883);
         rc(8'h08, 1);
         rc(8'h18, 8'h80);
         $display("copy done");
      end
   endtask
   task t_rot;
      begin
         bus(1, 8'h18, 8'h81);
         ex(14'h0D03);
         rc(8'h04, 3);
         rc(8'h08, 1);
         bus(1, 8'h08, 4);
         ex(14'h0D83);
         rc(8'h18, 2);
         rc(8'h08, 5);
         $display("rotate done");
      end
   endtask
   task t_ret;
      begin
         bus(1, 8'h10, 16'h0123);
         bus(1, 0, 16'h3477);
         // Back to back: this write stalls on the two-cycle return
         bus(1, 8'h08, 0);
         rc(8'h04, 8'h77);
         rc(8'h0C, 16'h0123);
         rc(8'h10, 0);
         bus(1, 8'h10, 16'h0456);
         rc(8'h10, 32'h0000_1000);
         ex(14'h0009);
         cyc_chk(2);
         rc(8'h0C, 16'h0456);
         rc(8'h08, 8'h80);
         rc(8'h10, 0);
         bus(1, 8'h10, 16'h0789);
         ex(14'h3455);
         cyc_chk(2);
         rc(8'h04, 8'h55);
         rc(8'h0C, 16'h0789);
         rc(8'h08, 8'h80);
         $display("return done");
      end
   endtask
   task t_nop;
      begin
         ex(14'h0000);
         cyc_chk(1);
         rc(8'h04, 8'h55);
         rc(8'h08, 8'h80);
         rc(8'h0C, 16'h078A);
         rc(8'h10, 0);
         rc(8'h20, 0);
         $display("nop done");
      end
   endtask
   task complete_run;
      begin
         $display("checks %0d errors %0d", cmp_count, error_cnt);
         if (error_cnt == 0 && cmp_count > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   initial begin
      repeat (3) @(posedge clk);
      resetn <= 1;
      t_load;
      t_copy;
      t_rot;
      t_ret;
      t_nop;
      complete_run;
   end
endmodule
